// >>> shared/flash_host_regs.svh
// Register offsets, field positions and timing counts of the flash host controller.
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL    5'h00
`define OFS_ADDR    5'h04
`define OFS_DATA    5'h08
`define OFS_CMD     5'h0C
`define OFS_STAT    5'h10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_BYTE   0
`define CTRL_STBY   1
`define CTRL_TOG    2
`define CMD_RD      0
`define CMD_WR      1
`define CMD_RST     2
`define CMD_WAIT    3
`define CMD_FORCE   4
`define STAT_IDLE   0
`define STAT_RDY    1
`define STAT_REF    2
`define STAT_DONE   3
`define TOG_BIT     6
`define CTRL_RESET  3'h0
// ----------------------------------------
// Timing in ns and derived cycle counts
// ----------------------------------------
`define CLK_NS      5
`define T_ACC_NS    70
`define T_WE_NS     35
`define T_REC_NS    20
`define T_RST_NS    500
`define T_BUSY_NS   90
`define ACC_CYC     (8'((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS))
`define WE_CYC      (8'((`T_WE_NS + `CLK_NS - 1) / `CLK_NS))
`define REC_CYC     (8'((`T_REC_NS + `CLK_NS - 1) / `CLK_NS))
`define RST_CYC     (8'((`T_RST_NS + `CLK_NS - 1) / `CLK_NS))
`define BUSY_CYC    (8'((`T_BUSY_NS + `CLK_NS - 1) / `CLK_NS))
`endif

// >>> shared/flash_host_pkg.sv
// Types shared by the flash host controller.
package flash_host_pkg;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_RD   = 3'b001,
		S_WR   = 3'b010,
		S_WH   = 3'b011,
		S_REC  = 3'b100,
		S_RST  = 3'b101,
		S_PIN  = 3'b110
	} state_t;
	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic rst_n;
		logic byte_n;
		logic dq_oe_n;
	} flash_ctl_t;
endpackage

// >>> hw/flash_host.sv
// Wishbone-driven host controller that runs bus cycles on a parallel NOR flash.
// Summary of operation
// - Commands are plain write cycles to flash.
// - Bypass mode programs with two writes.
// - Completion via ready pin or toggle bits.
// - Host may deselect flash for standby.
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`include "flash_host_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module flash_host
	import flash_host_pkg::*;
(
	// Clock and reset.
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	// Wishbone slave.
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [4:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	// Flash pins.
	output logic      [19:0] flash_addr_out,
	output logic      [15:0] dq_out,
	input  wire logic [15:0] dq_in,
	output flash_ctl_t       flash_ctl_out,
	input  wire logic        ready_busy_n_in
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		state_t     st;
		logic [7:0] cnt;
		flash_ctl_t ctl;
		logic [2:0]  ctrl;
		logic [19:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [19:0] fa;
		logic [15:0] dq;
		logic        poll;
		logic        first;
		logic        tog;
		logic        rdy;
		logic        refused;
		logic        done;
		logic        ack;
		logic [31:0] dat;
	} core_t;

	core_t s_ff;
	core_t nxt_s;
	logic  req;
	logic  cmd_wr;
	logic  refuse;

	// Reset starts with a flash reset pulse so the part is known to read array.
	localparam core_t RESET_VAL = '{
		st: S_RST, cnt: `RST_CYC - 8'h01,
		ctl: '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, rst_n: 1'b0, byte_n: 1'b1,
			dq_oe_n: 1'b1},
		ctrl: `CTRL_RESET, addr: 20'h00000, wdata: 16'h0000, rdata: 16'h0000,
		fa: 20'h00000, dq: 16'h0000, poll: 1'b0, first: 1'b0, tog: 1'b0,
		rdy: 1'b0, refused: 1'b0, done: 1'b0, ack: 1'b0, dat: 32'h00000000};

	assign req    = wb_cyc_in & wb_stb_in & ~s_ff.ack;
	assign cmd_wr = req & wb_we_in & wb_sel_in[0] & (wb_adr_in == `OFS_CMD);
	// A write cycle while the flash is busy could corrupt an embedded algorithm,
	// so with the sequencer in S_IDLE only writes without the force bit are refused then; reads, waits, resets and forced writes (suspend, exit) get through.
	// Outside S_IDLE every command is refused.
	assign refuse = cmd_wr & ((s_ff.st != S_IDLE) |
		(wb_dat_in[`CMD_WR] & ~s_ff.rdy & ~wb_dat_in[`CMD_FORCE]));

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_s     = s_ff;
		nxt_s.ack = 1'b0;
		nxt_s.rdy = ready_busy_n_in;
		// Bus slave: answer one cycle after the request, unmapped reads give zero.
		if (req) begin
			nxt_s.ack = 1'b1;
			nxt_s.dat = 32'h00000000;
			if (wb_we_in && wb_sel_in[0]) begin
				case (wb_adr_in)
					`OFS_CTRL: nxt_s.ctrl  = wb_dat_in[2:0];
					`OFS_ADDR: nxt_s.addr  = wb_dat_in[19:0];
					`OFS_DATA: nxt_s.wdata = wb_dat_in[15:0];
					`OFS_STAT: begin
						if (wb_dat_in[`STAT_DONE]) nxt_s.done = 1'b0;
						if (wb_dat_in[`STAT_REF]) nxt_s.refused = 1'b0;
					end
					default: ;
				endcase
			end else if (!wb_we_in) begin
				case (wb_adr_in)
					`OFS_CTRL: nxt_s.dat = {29'h0, s_ff.ctrl};
					`OFS_ADDR: nxt_s.dat = {12'h000, s_ff.addr};
					`OFS_DATA: nxt_s.dat = {16'h0000, s_ff.rdata};
					`OFS_STAT: nxt_s.dat = {28'h0, s_ff.done, s_ff.refused,
						s_ff.rdy, s_ff.st == S_IDLE};
					default:   nxt_s.dat = 32'h00000000;
				endcase
			end
		end
		// Sticky set wins over a software clear in the same cycle.
		if (refuse) nxt_s.refused = 1'b1;
		nxt_s.ctl.byte_n = ~s_ff.ctrl[`CTRL_BYTE];
		// Sequencer for flash bus cycles.
		case (s_ff.st)
			S_IDLE: begin
				// Address is held so the flash can drop into automatic sleep.
				nxt_s.ctl.ce_n = 1'b1;
				if (cmd_wr && !refuse) begin
					if (wb_dat_in[`CMD_RST]) begin
						nxt_s.ctl.rst_n = 1'b0;
						nxt_s.cnt       = `RST_CYC - 8'h01;
						nxt_s.st        = S_RST;
					end else if (wb_dat_in[`CMD_WR]) begin
						nxt_s.fa          = s_ff.addr;
						nxt_s.dq          = s_ff.ctrl[`CTRL_BYTE] ?
							{8'h00, s_ff.wdata[7:0]} : s_ff.wdata;
						nxt_s.ctl.ce_n    = 1'b0;
						nxt_s.ctl.we_n    = 1'b0;
						nxt_s.ctl.dq_oe_n = 1'b0;
						nxt_s.cnt         = `WE_CYC - 8'h01;
						nxt_s.st          = S_WR;
					end else if (wb_dat_in[`CMD_WAIT]) begin
						nxt_s.done  = 1'b0;
						nxt_s.poll  = s_ff.ctrl[`CTRL_TOG];
						nxt_s.first = 1'b1;
						nxt_s.cnt   = `BUSY_CYC - 8'h01;
						nxt_s.st    = s_ff.ctrl[`CTRL_TOG] ? S_REC : S_PIN;
					end else if (wb_dat_in[`CMD_RD]) begin
						nxt_s.fa       = s_ff.addr;
						nxt_s.ctl.ce_n = 1'b0;
						nxt_s.ctl.oe_n = 1'b0;
						nxt_s.cnt      = `ACC_CYC - 8'h01;
						nxt_s.st       = S_RD;
					end
				end
			end
			S_RD: begin
				if (s_ff.cnt != 8'h00) begin
					nxt_s.cnt = s_ff.cnt - 8'h01;
				end else begin
					nxt_s.ctl.ce_n = 1'b1;
					nxt_s.ctl.oe_n = 1'b1;
					nxt_s.cnt      = `REC_CYC - 8'h01;
					nxt_s.st       = S_REC;
					if (!s_ff.poll) begin
						nxt_s.rdata = s_ff.ctrl[`CTRL_BYTE] ?
							{8'h00, dq_in[7:0]} : dq_in;
					end else begin
						// Two reads with equal toggle bit mean the algorithm is over.
						nxt_s.rdata = dq_in;
						nxt_s.tog   = dq_in[`TOG_BIT];
						nxt_s.first = 1'b0;
						if (!s_ff.first && dq_in[`TOG_BIT] == s_ff.tog) begin
							nxt_s.poll = 1'b0;
							nxt_s.done = 1'b1;
						end
					end
				end
			end
			S_WR: begin
				if (s_ff.cnt != 8'h00) begin
					nxt_s.cnt = s_ff.cnt - 8'h01;
				end else begin
					nxt_s.ctl.we_n = 1'b1;
					nxt_s.cnt      = `REC_CYC - 8'h01;
					nxt_s.st       = S_WH;
				end
			end
			S_WH: begin
				// Data and select stay put past the rising strobe for hold time.
				if (s_ff.cnt != 8'h00) begin
					nxt_s.cnt = s_ff.cnt - 8'h01;
				end else begin
					nxt_s.ctl.ce_n    = 1'b1;
					nxt_s.ctl.dq_oe_n = 1'b1;
					nxt_s.st          = S_IDLE;
				end
			end
			S_REC: begin
				if (s_ff.cnt != 8'h00) begin
					nxt_s.cnt = s_ff.cnt - 8'h01;
				end else if (s_ff.poll) begin
					nxt_s.ctl.ce_n = 1'b0;
					nxt_s.ctl.oe_n = 1'b0;
					nxt_s.cnt      = `ACC_CYC - 8'h01;
					nxt_s.st       = S_RD;
				end else begin
					nxt_s.st = S_IDLE;
				end
			end
			S_RST: begin
				if (s_ff.cnt != 8'h00) begin
					nxt_s.cnt = s_ff.cnt - 8'h01;
				end else begin
					nxt_s.ctl.rst_n = 1'b1;
					nxt_s.cnt       = `REC_CYC - 8'h01;
					nxt_s.st        = S_REC;
				end
			end
			S_PIN: begin
				// The pin is ignored until the flash has had time to show busy.
				if (s_ff.cnt != 8'h00) begin
					nxt_s.cnt = s_ff.cnt - 8'h01;
				end else if (ready_busy_n_in) begin
					nxt_s.done = 1'b1;
					nxt_s.st   = S_IDLE;
				end
			end
			default: nxt_s = RESET_VAL;
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			s_ff <= RESET_VAL;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs come straight from the state register.
	assign wb_dat_out     = s_ff.dat;
	assign wb_ack_out     = s_ff.ack;
	assign flash_addr_out = s_ff.fa;
	assign dq_out         = s_ff.dq;
	assign flash_ctl_out  = s_ff.ctl;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence we_pulse;
		!s_ff.ctl.we_n[*7] ##1 s_ff.ctl.we_n;
	endsequence
	sequence rd_access;
		!s_ff.ctl.oe_n[*8] ##7 s_ff.ctl.oe_n;
	endsequence

	chk_oe_needs_ce: assert property (@(posedge mclk_in) disable iff (rst_in)
		!s_ff.ctl.oe_n |-> !s_ff.ctl.ce_n)
		else $error("Output enable without chip select.");
	chk_no_contention: assert property (@(posedge mclk_in) disable iff (rst_in)
		!s_ff.ctl.dq_oe_n |-> s_ff.ctl.oe_n)
		else $error("Host drives data while flash outputs enabled.");
	chk_we_pulse_len: assert property (@(posedge mclk_in) disable iff (rst_in)
		$fell(s_ff.ctl.we_n) |-> we_pulse)
		else $error("Write strobe width wrong.");
	chk_rd_access_len: assert property (@(posedge mclk_in) disable iff (rst_in)
		$fell(s_ff.ctl.oe_n) |-> rd_access)
		else $error("Read access time wrong.");
	chk_addr_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
		!s_ff.ctl.ce_n && $past(!s_ff.ctl.ce_n) |-> $stable(s_ff.fa) && $stable(s_ff.dq))
		else $error("Address or data moved during a cycle.");
	chk_busy_refused: assert property (@(posedge mclk_in) disable iff (rst_in)
		cmd_wr && wb_dat_in[`CMD_WR] && !wb_dat_in[`CMD_FORCE] && !s_ff.rdy
		|=> s_ff.refused && s_ff.ctl.we_n)
		else $error("Write issued while flash busy.");
	chk_reset_quiet: assert property (@(posedge mclk_in) disable iff (rst_in)
		!s_ff.ctl.rst_n |-> s_ff.ctl.ce_n && s_ff.ctl.we_n)
		else $error("Flash selected during reset pulse.");
	chk_idle_standby: assert property (@(posedge mclk_in) disable iff (rst_in)
		s_ff.st == S_IDLE && $past(s_ff.st == S_IDLE) |-> s_ff.ctl.ce_n && $stable(s_ff.fa))
		else $error("Flash not in standby while idle.");
	chk_pin_done: assert property (@(posedge mclk_in) disable iff (rst_in)
		s_ff.st == S_PIN && s_ff.cnt == 8'h00 && ready_busy_n_in
		|=> s_ff.done && s_ff.st == S_IDLE)
		else $error("Ready pin completion missed.");
	chk_byte_lanes: assert property (@(posedge mclk_in) disable iff (rst_in)
		!s_ff.ctl.dq_oe_n && !s_ff.ctl.byte_n |-> s_ff.dq[15:8] == 8'h00)
		else $error("Upper data lines driven in byte mode.");
	chk_ack_once: assert property (@(posedge mclk_in) disable iff (rst_in)
		s_ff.ack |=> !s_ff.ack)
		else $error("Bus ack held more than one cycle.");

endmodule
`default_nettype wire

// >>> verif/flash_dev_model.sv
// Behavioural model of the parallel flash device behind the host controller.
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model
	import flash_host_pkg::*;
#(
	parameter int BUSY_CYC = 200
)(
	// Clock of the sampling model.
	input  wire logic        mclk_in,
	// Pins from the host.
	input  wire logic [19:0] addr_in,
	input  wire logic [15:0] dq_in,
	input  wire flash_ctl_t  ctl_in,
	// Pins to the host.
	output logic      [15:0] dq_out,
	output logic             ready_busy_n_out
);
	logic [15:0] mem [logic [19:0]];
	logic [19:0] pa;
	logic [15:0] pd;
	logic [15:0] v;
	int          busy;
	logic        tog;
	logic        we_q;
	logic        oe_q;

	// Erased cells read as all ones.
	function automatic logic [15:0] rd(input logic [19:0] a);
		return mem.exists(a) ? mem[a] : 16'hFFFF;
	endfunction

	initial begin
		dq_out = 16'h0000;
		ready_busy_n_out = 1'b1;
		busy = 0;
		tog = 1'b0;
		we_q = 1'b1;
		oe_q = 1'b1;
	end

	// Command capture, embedded program and read path in one process.
	always @(posedge mclk_in) begin
		we_q <= ctl_in.we_n;
		oe_q <= ctl_in.oe_n;
		v = rd(addr_in);
		if (!ctl_in.rst_n) begin
			busy <= 0;
			ready_busy_n_out <= 1'b1;
		end else if (busy > 0) begin
			busy <= busy - 1;
			if (busy == 1) begin
				mem[pa] = rd(pa) & pd;
				ready_busy_n_out <= 1'b1;
			end
		end else if (!ctl_in.ce_n && !we_q && ctl_in.we_n) begin
			pa <= addr_in;
			pd <= ctl_in.byte_n ? dq_in : {8'hFF, dq_in[7:0]};
			busy <= BUSY_CYC;
			ready_busy_n_out <= 1'b0;
		end
		// Released lines flip every cycle so a stray sample cannot match by luck.
		if (!ctl_in.ce_n && !ctl_in.oe_n) begin
			if (oe_q && busy > 0) begin
				tog <= ~tog;
			end
			if (busy > 0) begin
				dq_out <= {9'h000, tog, 6'h00};
			end else if (ctl_in.byte_n) begin
				dq_out <= v;
			end else begin
				dq_out <= {~dq_out[15:8], v[7:0]};
			end
		end else begin
			dq_out <= ~dq_out;
		end
	end
endmodule
`default_nettype wire

// >>> verif/test_flash_host.sv
// Self-checking testbench of the flash host controller with a flash model.
`include "flash_host_regs.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
	$display("[ERR] %0t %s", $time, msg); end end
module test_flash_host;
	import flash_host_pkg::*;
	logic        mclk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [4:0]  wb_adr = 5'h00;
	logic [3:0]  wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] wb_rdat;
	logic        wb_ack;
	logic [19:0] fa;
	logic [15:0] fdo;
	logic [15:0] fdi;
	flash_ctl_t  ctl;
	logic        rb_n;
	int          n_fail = 0;
	int          n_tests = 0;
	logic [15:0] ref_mem [logic [19:0]];

	flash_host flash_host_inst (.mclk_in(mclk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc),
		.wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
		.wb_dat_in(wb_dat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack),
		.flash_addr_out(fa), .dq_out(fdo), .dq_in(fdi), .flash_ctl_out(ctl),
		.ready_busy_n_in(rb_n));
	flash_dev_model flash_dev_model_inst (.mclk_in(mclk_in), .addr_in(fa), .dq_in(fdo),
		.ctl_in(ctl), .dq_out(fdi), .ready_busy_n_out(rb_n));

	// Free-running 200 MHz clock.
	always #2.5 mclk_in = ~mclk_in;

	function automatic logic [15:0] ref_rd(input logic [19:0] a);
		return ref_mem.exists(a) ? ref_mem[a] : 16'hFFFF;
	endfunction

	task automatic finish_test();
		if (n_fail == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Classic single Wishbone cycle, held until ack is sampled high.
	task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		i = 0;
		@(posedge mclk_in);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_sel <= 4'hF;
		wb_dat <= d;
		do begin
			@(posedge mclk_in);
			i++;
		end while (wb_ack !== 1'b1 && i < 20);
		q = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_sel <= 4'h0;
		if (i >= 20) begin
			n_fail++;
			finish_test();
		end
	endtask

	// Polls the idle flag; a poll that never ends is a failure.
	task automatic wait_idle();
		logic [31:0] q;
		int i;
		i = 0;
		q = 32'h0;
		while (q[`STAT_IDLE] !== 1'b1) begin
			wb(`OFS_STAT, 1'b0, 32'h0, q);
			i++;
			if (i > 600) begin
				n_fail++;
				finish_test();
			end
		end
	endtask

	// Reads one flash location and compares it with the reference.
	task automatic rd_chk(input logic [19:0] a, input logic bm);
		logic [31:0] q;
		logic [15:0] e;
		e = ref_rd(a);
		wb(`OFS_ADDR, 1'b1, {12'h000, a}, q);
		wb(`OFS_CMD, 1'b1, 32'h1, q);
		wait_idle();
		wb(`OFS_DATA, 1'b0, 32'h0, q);
		`CHK(q, bm ? {24'h0, e[7:0]} : {16'h0, e}, "flash read data")
	endtask

	initial begin
		logic [31:0] q;
		logic [19:0] a;
		logic [15:0] d;
		logic        bm;
		void'($urandom(32'h3D07));
		repeat (4) @(posedge mclk_in);
		rst_in <= 1'b0;
		wb(`OFS_CMD, 1'b1, 32'h2, q);
		wb(`OFS_STAT, 1'b0, 32'h0, q);
		`CHK(q[`STAT_REF], 1'b1, "command during reset pulse accepted")
		wait_idle();
		wb(`OFS_STAT, 1'b1, 32'hC, q);
		wb(`OFS_STAT, 1'b0, 32'h0, q);
		`CHK(q[3:0], 4'h3, "status after reset")
		wb(5'h14, 1'b0, 32'h0, q);
		`CHK(q, 32'h0, "unmapped read")
		// Word and byte mode, each with pin and toggle completion.
		for (int k = 0; k < 4; k++) begin
			bm = k[0];
			a = 20'($urandom);
			d = 16'($urandom);
			wb(`OFS_CTRL, 1'b1, {29'h0, k[1], 1'b0, bm}, q);
			wb(`OFS_ADDR, 1'b1, {12'h000, a}, q);
			wb(`OFS_DATA, 1'b1, {16'h0, d}, q);
			wb(`OFS_CMD, 1'b1, 32'h2, q);
			wait_idle();
			wb(`OFS_STAT, 1'b0, 32'h0, q);
			`CHK(q[`STAT_RDY], 1'b0, "busy pin not reported")
			wb(`OFS_CMD, 1'b1, 32'h2, q);
			wb(`OFS_STAT, 1'b0, 32'h0, q);
			`CHK(q[`STAT_REF], 1'b1, "write while busy accepted")
			wb(`OFS_STAT, 1'b1, 32'hC, q);
			wb(`OFS_CMD, 1'b1, 32'h8, q);
			wait_idle();
			wb(`OFS_STAT, 1'b0, 32'h0, q);
			`CHK(q[3:0], 4'hB, "completion not seen")
			ref_mem[a] = ref_rd(a) & (bm ? {8'hFF, d[7:0]} : d);
			rd_chk(a, bm);
			rd_chk(a ^ 20'h00001, bm);
		end
		// A flash reset pulse in mid-program leaves the cell unchanged.
		wb(`OFS_CTRL, 1'b1, 32'h0, q);
		a = 20'($urandom);
		wb(`OFS_ADDR, 1'b1, {12'h000, a}, q);
		wb(`OFS_DATA, 1'b1, 32'h0, q);
		wb(`OFS_CMD, 1'b1, 32'h2, q);
		wait_idle();
		wb(`OFS_CMD, 1'b1, 32'h4, q);
		wait_idle();
		rd_chk(a, 1'b0);
		finish_test();
	end
endmodule
`default_nettype wire
